// [rtl/tdm_port_pkg.sv]
// Package: register map, field layout and reset values of the TDM link port
package tdm_port_pkg;
   localparam int NUM_LINKS = 16;
   localparam int NUM_REFS  = 4;
   localparam int NUM_PLL   = 2;
   localparam int ADDR_W    = 8;
   localparam int DATA_W    = 32;

   // Byte addresses; per-link blocks sit at base + 4*link
   localparam logic [ADDR_W-1:0] TX_CTRL_BASE  = 8'h00;
   localparam logic [ADDR_W-1:0] RX_FREQ_BASE  = 8'h40;
   localparam logic [ADDR_W-1:0] LINK_EN_ADDR  = 8'h80;
   localparam logic [ADDR_W-1:0] PLL_SEL_ADDR  = 8'h84;
   localparam logic [ADDR_W-1:0] STATUS_ADDR   = 8'h88;
   localparam logic [ADDR_W-1:0] SLOT_EN_BASE  = 8'hC0;

   // TX link control fields
   localparam int TXC_DIR_OUT_BIT = 0;
   localparam int TXC_POL_BIT     = 1;
   localparam int TXC_SRC_LSB     = 4;
   localparam int TXC_SRC_W       = 5;
   localparam logic [DATA_W-1:0] TXC_RST = 32'h0000_0000;

   // RX expected frequency: rx clock period in system clocks
   localparam int RXF_W = 16;
   localparam logic [RXF_W-1:0] RXF_RST = 16'h0028;
   localparam int RXF_TOL = 2;

   // TX slot map: 32 slots per frame, one bit each
   localparam int SLOTS    = 32;
   localparam int SLOT_W   = 5;

   // PLL reference select fields: 5 bits each
   localparam int PLL_SEL_W = 5;

   // Source select encoding: 0..15 rx clocks, 16..19 ref clocks
   localparam logic [TXC_SRC_W-1:0] SRC_REF0 = 5'h10;
endpackage

// [rtl/tdm_clk_if.sv]
// Interface: synchronised clock levels passed to the per-link lane
`timescale 1ns/10ps
interface tdm_clk_if;
   logic tx_clk;
   logic rx_clk;
   logic rx_data;
   modport ctrl (output tx_clk, output rx_clk, output rx_data);
   modport lane (input tx_clk, input rx_clk, input rx_data);
endinterface : tdm_clk_if

// [rtl/tdm_link_lane.sv]
// Per-link lane: edge finding, serial shift, slot gating, rx clock check
`timescale 1ns/10ps
module tdm_link_lane
   import tdm_port_pkg::*;
(
   input  wire logic                   i_clk,
   input  wire logic                   i_nrst,
   tdm_clk_if.lane                     clk_if,
   input  wire logic                   i_enable,
   input  wire logic                   i_pol,
   input  wire logic [SLOTS-1:0]       i_slot_en,
   input  wire logic [RXF_W-1:0]       i_rx_period,
   input  wire logic [7:0]             i_tx_byte,
   output logic                        o_tx_bit,
   output logic                        o_tx_oe_n,
   output logic [7:0]                  o_rx_byte,
   output logic                        o_rx_valid,
   output logic                        o_rx_freq_ok
);
   logic             tx_prev_ff;
   logic             rx_prev_ff;
   logic [2:0]       bit_cnt_ff;
   logic [SLOT_W-1:0] slot_ff;
   logic [SLOT_W-1:0] line_slot_ff;
   logic [7:0]       tx_sh_ff;
   logic [7:0]       rx_sh_ff;
   logic [2:0]       rx_cnt_ff;
   logic [RXF_W-1:0] per_cnt_ff;
   logic             launch;
   logic             rx_rise;

   // Launch on the selected active edge of this link's own tx clock
   assign launch  = i_pol ? (tx_prev_ff & ~clk_if.tx_clk)
                          : (~tx_prev_ff & clk_if.tx_clk);
   assign rx_rise = ~rx_prev_ff & clk_if.rx_clk;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         tx_prev_ff <= 1'b0;
         rx_prev_ff <= 1'b0;
      end else begin
         tx_prev_ff <= clk_if.tx_clk;
         rx_prev_ff <= clk_if.rx_clk;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         bit_cnt_ff <= 3'h0;
         slot_ff    <= '0;
         tx_sh_ff   <= 8'h00;
         line_slot_ff <= '0;
         o_tx_bit   <= 1'b0;
         o_tx_oe_n  <= 1'b1;
      end else if (!i_enable) begin
         bit_cnt_ff <= 3'h0;
         slot_ff    <= '0;
         o_tx_oe_n  <= 1'b1;
      end else if (launch) begin
         o_tx_bit   <= (bit_cnt_ff == 3'h0) ? i_tx_byte[7] : tx_sh_ff[7];
         tx_sh_ff   <= (bit_cnt_ff == 3'h0) ? {i_tx_byte[6:0], 1'b0}
                                            : {tx_sh_ff[6:0], 1'b0};
         o_tx_oe_n  <= ~i_slot_en[slot_ff];
         bit_cnt_ff <= bit_cnt_ff + 3'h1;
         line_slot_ff <= slot_ff;
         if (bit_cnt_ff == 3'h7) begin
            slot_ff <= slot_ff + 1'b1;
         end
      end else if (!i_slot_en[line_slot_ff]) begin
         // Slot dropped mid-slot: float at once, never re-drive before a launch
         o_tx_oe_n  <= 1'b1;
      end
   end

   // Receive: sample on rising edge of this link's rx clock
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rx_sh_ff   <= 8'h00;
         rx_cnt_ff  <= 3'h0;
         o_rx_byte  <= 8'h00;
         o_rx_valid <= 1'b0;
      end else begin
         o_rx_valid <= 1'b0;
         if (i_enable && rx_rise) begin
            rx_sh_ff  <= {rx_sh_ff[6:0], clk_if.rx_data};
            rx_cnt_ff <= rx_cnt_ff + 3'h1;
            if (rx_cnt_ff == 3'h7) begin
               o_rx_byte  <= {rx_sh_ff[6:0], clk_if.rx_data};
               o_rx_valid <= 1'b1;
            end
         end
      end
   end

   // Period check against programmed expectation; a stopped clock fails
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         per_cnt_ff   <= '0;
         o_rx_freq_ok <= 1'b0;
      end else if (rx_rise) begin
         per_cnt_ff   <= RXF_W'(1);
         o_rx_freq_ok <= (per_cnt_ff + RXF_W'(RXF_TOL) >= i_rx_period) &&
                         (per_cnt_ff <= i_rx_period + RXF_W'(RXF_TOL));
      end else if (per_cnt_ff != '1) begin
         per_cnt_ff <= per_cnt_ff + 1'b1;
         if (per_cnt_ff > i_rx_period + RXF_W'(RXF_TOL)) begin
            o_rx_freq_ok <= 1'b0;
         end
      end
   end
endmodule : tdm_link_lane

// [rtl/tdm_link_port.sv]
// Top: serial TDM link port with tx clock routing and Avalon-MM registers
// How it works
// - Tx data line floats in unused slots and while its link is disabled.
// - Tx data launches aligned to the same link's tx clock pin.
// - Rx data arrives aligned to rx clock; device samples with that clock.
// - Per-link register bit makes tx clock pin an input or output.
// - Output tx clock comes from any rx clock or any reference clock.
// - Per-link polarity bit sets the active tx clock edge.
// - Per-link expected rx clock period is held and checked against input.
// - Four reference clock inputs are routable to any link's tx clock.
// - Two reference outputs drive an external PLL.
//
// Implementation choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/10ps
module tdm_link_port
   import tdm_port_pkg::*;
(
   input  wire logic                               i_clk,
   input  wire logic                               i_nrst,
   input  wire logic [tdm_port_pkg::ADDR_W-1:0]    i_avs_address,
   input  wire logic                               i_avs_read,
   input  wire logic                               i_avs_write,
   input  wire logic [tdm_port_pkg::DATA_W-1:0]    i_avs_writedata,
   input  wire logic [3:0]                         i_avs_byteenable,
   output logic [tdm_port_pkg::DATA_W-1:0]         o_avs_readdata,
   output logic                                    o_avs_waitrequest,
   output logic [1:0]                              o_avs_response,
   output logic [tdm_port_pkg::NUM_LINKS-1:0]      o_serial_tx_line,
   output logic [tdm_port_pkg::NUM_LINKS-1:0]      o_serial_tx_line_oe_n,
   input  wire logic [tdm_port_pkg::NUM_LINKS-1:0] i_serial_rx_line,
   input  wire logic [tdm_port_pkg::NUM_LINKS-1:0] i_link_tx_clock_pin,
   output logic [tdm_port_pkg::NUM_LINKS-1:0]      o_link_tx_clock_pin,
   output logic [tdm_port_pkg::NUM_LINKS-1:0]      o_link_tx_clock_pin_oe_n,
   input  wire logic [tdm_port_pkg::NUM_LINKS-1:0] i_link_rx_clock_in,
   input  wire logic [tdm_port_pkg::NUM_REFS-1:0]  i_dejittered_ref_clock_in,
   output logic [tdm_port_pkg::NUM_PLL-1:0]        o_ext_pll_ref_out,
   input  wire logic [8*tdm_port_pkg::NUM_LINKS-1:0] i_tx_bytes,
   output logic [8*tdm_port_pkg::NUM_LINKS-1:0]    o_rx_bytes,
   output logic [tdm_port_pkg::NUM_LINKS-1:0]      o_rx_valid
);
   localparam int SRCS = NUM_LINKS + NUM_REFS;
   localparam int SYNC_W = 3 * NUM_LINKS + NUM_REFS;

   // Control registers
   logic [DATA_W-1:0]     tx_ctrl_ff [NUM_LINKS];
   logic [RXF_W-1:0]      rx_freq_ff [NUM_LINKS];
   logic [SLOTS-1:0]      slot_en_ff [NUM_LINKS];
   logic [NUM_LINKS-1:0]  link_en_ff;
   logic [2*PLL_SEL_W-1:0] pll_sel_ff;

   // Two-stage synchronisers on every pin that runs off another clock
   logic [SYNC_W-1:0]     meta_ff;
   logic [SYNC_W-1:0]     sync_ff;
   logic [NUM_LINKS-1:0]  tx_pin_s;
   logic [NUM_LINKS-1:0]  rx_clk_s;
   logic [NUM_LINKS-1:0]  rx_dat_s;
   logic [NUM_REFS-1:0]   ref_s;
   logic [SRCS-1:0]       src_vec;
   logic [NUM_LINKS-1:0]  tx_out_ff;
   logic [NUM_LINKS-1:0]  tx_oe_n_ff;
   logic [NUM_LINKS-1:0]  freq_ok;
   logic [NUM_LINKS-1:0]  tx_bit;
   logic [NUM_LINKS-1:0]  tx_oe_n;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= {i_dejittered_ref_clock_in, i_serial_rx_line,
                     i_link_rx_clock_in, i_link_tx_clock_pin};
         sync_ff <= meta_ff;
      end
   end

   assign tx_pin_s = sync_ff[NUM_LINKS-1:0];
   assign rx_clk_s = sync_ff[2*NUM_LINKS-1:NUM_LINKS];
   assign rx_dat_s = sync_ff[3*NUM_LINKS-1:2*NUM_LINKS];
   assign ref_s    = sync_ff[SYNC_W-1:3*NUM_LINKS];
   assign src_vec  = {ref_s, rx_clk_s};

   // One wait state per access, so read data and response come from flops
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_avs_waitrequest <= 1'b1;
      end else begin
         o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         for (int i = 0; i < NUM_LINKS; i++) begin
            tx_ctrl_ff[i] <= TXC_RST;
            rx_freq_ff[i] <= RXF_RST;
            slot_en_ff[i] <= '0;
         end
         link_en_ff <= '0;
         pll_sel_ff <= '0;
      end else if (i_avs_write && !o_avs_waitrequest) begin
         for (int i = 0; i < NUM_LINKS; i++) begin
            if (i_avs_address == TX_CTRL_BASE + ADDR_W'(4 * i)) begin
               for (int b = 0; b < 4; b++) begin
                  if (i_avs_byteenable[b]) begin
                     tx_ctrl_ff[i][8*b+:8] <= i_avs_writedata[8*b+:8];
                  end
               end
            end
            if (i_avs_address == RX_FREQ_BASE + ADDR_W'(4 * i)) begin
               for (int b = 0; b < 2; b++) begin
                  if (i_avs_byteenable[b]) begin
                     rx_freq_ff[i][8*b+:8] <= i_avs_writedata[8*b+:8];
                  end
               end
            end
            if (i_avs_address == SLOT_EN_BASE + ADDR_W'(4 * i)) begin
               for (int b = 0; b < 4; b++) begin
                  if (i_avs_byteenable[b]) begin
                     slot_en_ff[i][8*b+:8] <= i_avs_writedata[8*b+:8];
                  end
               end
            end
         end
         if (i_avs_address == LINK_EN_ADDR) begin
            if (i_avs_byteenable[0]) begin
               link_en_ff[7:0] <= i_avs_writedata[7:0];
            end
            if (i_avs_byteenable[1]) begin
               link_en_ff[15:8] <= i_avs_writedata[15:8];
            end
         end
         if (i_avs_address == PLL_SEL_ADDR && i_avs_byteenable[1:0] == 2'h3) begin
            pll_sel_ff <= i_avs_writedata[2*PLL_SEL_W-1:0];
         end
      end
   end

   // Read mux, loaded during the wait state; unmapped addresses read zero
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_avs_readdata <= '0;
      end else begin
         o_avs_readdata <= '0;
         if (i_avs_address == LINK_EN_ADDR) begin
            o_avs_readdata <= DATA_W'(link_en_ff);
         end
         if (i_avs_address == PLL_SEL_ADDR) begin
            o_avs_readdata <= DATA_W'(pll_sel_ff);
         end
         if (i_avs_address == STATUS_ADDR) begin
            o_avs_readdata <= {freq_ok, tx_pin_s};
         end
         for (int i = 0; i < NUM_LINKS; i++) begin
            if (i_avs_address == TX_CTRL_BASE + ADDR_W'(4 * i)) begin
               o_avs_readdata <= tx_ctrl_ff[i];
            end
            if (i_avs_address == RX_FREQ_BASE + ADDR_W'(4 * i)) begin
               o_avs_readdata <= DATA_W'(rx_freq_ff[i]);
            end
            if (i_avs_address == SLOT_EN_BASE + ADDR_W'(4 * i)) begin
               o_avs_readdata <= slot_en_ff[i];
            end
         end
      end
   end

   // Decode error registered in the wait state, so it stands with the answer
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_avs_response <= 2'h0;
      end else if (!((i_avs_address & 8'h80) == 8'h00 ||
                     i_avs_address == LINK_EN_ADDR || i_avs_address == PLL_SEL_ADDR ||
                     i_avs_address == STATUS_ADDR ||
                     (i_avs_address & 8'hC0) == SLOT_EN_BASE)) begin
         o_avs_response <= 2'h3;
      end else begin
         o_avs_response <= 2'h0;
      end
   end

   // Tx clock pin routing; recreated clock runs at sys-clock resolution
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         tx_out_ff  <= '0;
         tx_oe_n_ff <= '1;
      end else begin
         for (int i = 0; i < NUM_LINKS; i++) begin
            tx_oe_n_ff[i] <= ~tx_ctrl_ff[i][TXC_DIR_OUT_BIT];
            tx_out_ff[i]  <= (tx_ctrl_ff[i][TXC_SRC_LSB+:TXC_SRC_W] < SRCS) ?
                             src_vec[tx_ctrl_ff[i][TXC_SRC_LSB+:TXC_SRC_W]] :
                             1'b0;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_ext_pll_ref_out <= '0;
      end else begin
         for (int p = 0; p < NUM_PLL; p++) begin
            o_ext_pll_ref_out[p] <= (pll_sel_ff[p*PLL_SEL_W+:PLL_SEL_W] < SRCS) ?
                                    src_vec[pll_sel_ff[p*PLL_SEL_W+:PLL_SEL_W]] :
                                    1'b0;
         end
      end
   end

   assign o_link_tx_clock_pin      = tx_out_ff;
   assign o_link_tx_clock_pin_oe_n = tx_oe_n_ff;
   assign o_serial_tx_line         = tx_bit;
   assign o_serial_tx_line_oe_n    = tx_oe_n;

   genvar g;
   generate
      for (g = 0; g < NUM_LINKS; g++) begin : g_lane
         tdm_clk_if cif ();
         // Launch off tx_out_ff when the pin is an output, off the synchronised pin level when it is an input
         assign cif.tx_clk  = tx_ctrl_ff[g][TXC_DIR_OUT_BIT] ? tx_out_ff[g]
                                                             : tx_pin_s[g];
         assign cif.rx_clk  = rx_clk_s[g];
         assign cif.rx_data = rx_dat_s[g];
         tdm_link_lane u_lane (
            .i_clk        (i_clk),
            .i_nrst       (i_nrst),
            .clk_if       (cif),
            .i_enable     (link_en_ff[g]),
            .i_pol        (tx_ctrl_ff[g][TXC_POL_BIT]),
            .i_slot_en    (slot_en_ff[g]),
            .i_rx_period  (rx_freq_ff[g]),
            .i_tx_byte    (i_tx_bytes[8*g+:8]),
            .o_tx_bit     (tx_bit[g]),
            .o_tx_oe_n    (tx_oe_n[g]),
            .o_rx_byte    (o_rx_bytes[8*g+:8]),
            .o_rx_valid   (o_rx_valid[g]),
            .o_rx_freq_ok (freq_ok[g])
         );
      end
   endgenerate
endmodule : tdm_link_port

// [sim/tdm_link_port_props.sv]
// Checker: port-level properties of the TDM link port
`timescale 1ns/10ps
module tdm_link_port_props
   import tdm_port_pkg::*;
(
   input wire logic                               i_clk,
   input wire logic                               i_nrst,
   input wire logic [tdm_port_pkg::ADDR_W-1:0]    i_avs_address,
   input wire logic                               i_avs_read,
   input wire logic                               i_avs_write,
   input wire logic [tdm_port_pkg::DATA_W-1:0]    i_avs_writedata,
   input wire logic                               o_avs_waitrequest,
   input wire logic [1:0]                         o_avs_response,
   input wire logic [tdm_port_pkg::NUM_LINKS-1:0] o_serial_tx_line_oe_n,
   input wire logic [tdm_port_pkg::NUM_LINKS-1:0] o_link_tx_clock_pin_oe_n,
   input wire logic [tdm_port_pkg::NUM_LINKS-1:0] i_link_rx_clock_in,
   input wire logic [tdm_port_pkg::NUM_REFS-1:0]  i_dejittered_ref_clock_in,
   input wire logic [tdm_port_pkg::NUM_PLL-1:0]   o_ext_pll_ref_out,
   input wire logic [tdm_port_pkg::NUM_LINKS-1:0] o_rx_valid
);
   logic [15:0] en_ff, dir_ff, slot_ff, live;
   logic [4:0]  sel_ff;
   logic        sel_set_ff, src_ff, take, unm;
   logic [3:0]  cnt_ff;
   logic [19:0] srcs;
   assign take = i_avs_write && !o_avs_waitrequest;
   assign unm  = i_avs_address >= 8'h8C && i_avs_address < 8'hC0;
   assign srcs = {i_dejittered_ref_clock_in, i_link_rx_clock_in};
   assign live = en_ff & slot_ff;
   // Shadow only what gates the pins; slot word kept as any-slot-used
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         en_ff <= 16'h0000;
         dir_ff <= 16'h0000;
         slot_ff <= 16'h0000;
         sel_ff <= 5'h00;
         sel_set_ff <= 1'b0;
      end else if (take) begin
         if (i_avs_address[7:6] == 2'b00) dir_ff[i_avs_address[5:2]] <= i_avs_writedata[0];
         if (i_avs_address[7:6] == 2'b11) slot_ff[i_avs_address[5:2]] <= |i_avs_writedata;
         if (i_avs_address == LINK_EN_ADDR) en_ff <= i_avs_writedata[15:0];
         if (i_avs_address == PLL_SEL_ADDR) begin
            sel_ff <= i_avs_writedata[4:0];
            sel_set_ff <= 1'b1;
         end
      end
   end
   // Output lags its source by sync and flop stages, so wait for a quiet source
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         src_ff <= 1'b0;
         cnt_ff <= 4'h0;
      end else begin
         src_ff <= srcs[sel_ff];
         if (!sel_set_ff || take || srcs[sel_ff] != src_ff) cnt_ff <= 4'h0;
         else if (cnt_ff != 4'hF) cnt_ff <= cnt_ff + 4'h1;
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   sequence s_unm_rd;
      i_avs_read && unm && !o_avs_waitrequest;
   endsequence
   a_wait_one_low: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_req_answered: assert property (
      (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("request not answered after one wait state");
   a_rd_decode_err: assert property (s_unm_rd |-> o_avs_response == 2'h3)
      else $error("unmapped read not refused");
   a_wr_decode_err: assert property (take && unm |-> o_avs_response == 2'h3)
      else $error("unmapped write not refused");
   a_mapped_okay: assert property ((i_avs_read || take) && !unm && !o_avs_waitrequest
      |-> o_avs_response == 2'h0) else $error("mapped access refused");
   a_tx_float_idle: assert property (
      live == $past(live, 3) |-> (o_serial_tx_line_oe_n | live) == 16'hFFFF)
      else $error("unused tx line driven");
   a_clk_pin_dir: assert property (
      dir_ff == $past(dir_ff, 3) |-> o_link_tx_clock_pin_oe_n == ~dir_ff)
      else $error("tx clock pin direction wrong");
   a_pll_ref_follow: assert property (
      cnt_ff > 4'h5 |-> o_ext_pll_ref_out[0] == src_ff) else $error("pll ref stale");
   a_rx_valid_pulse: assert property (
      |o_rx_valid |=> (o_rx_valid & $past(o_rx_valid)) == 16'h0)
      else $error("rx valid longer than one cycle");
endmodule // tdm_link_port_props
bind tdm_link_port tdm_link_port_props i_tdm_link_port_props (.i_clk, .i_nrst,
   .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_waitrequest,
   .o_avs_response, .o_serial_tx_line_oe_n, .o_link_tx_clock_pin_oe_n,
   .i_link_rx_clock_in, .i_dejittered_ref_clock_in, .o_ext_pll_ref_out, .o_rx_valid);

// [sim/tdm_xcvr_model.sv]
// Model: transceiver side clocks and serial receive data for all links
`timescale 1ns/10ps
module tdm_xcvr_model (
   output logic [15:0] o_rx_clk,
   output logic [15:0] o_rx_data,
   output logic [3:0]  o_ref_clk,
   output logic [15:0] o_tx_clk
);
   localparam logic [7:0] PAT = 8'h1D;
   int idx;
   initial begin
      o_rx_clk = 16'h0000;
      o_rx_data = {16{PAT[7]}};
      idx = 1;
      forever begin
         #80 o_rx_clk = 16'hFFFF;
         #80 o_rx_clk = 16'h0000;
         o_rx_data = {16{PAT[7-idx]}};
         idx = (idx + 1) % 8;
      end
   end
   // References offset from the rx clocks so routing mix-ups show
   initial begin
      o_ref_clk = 4'h0;
      #40;
      forever #80 o_ref_clk = ~o_ref_clk;
   end
   assign o_tx_clk = {16{~o_ref_clk[0]}};
endmodule // tdm_xcvr_model

// [sim/tb_tdm_link_port.sv]
// Testbench: registers, clock routing and serial traffic of the TDM link port
`timescale 1ns/10ps
module tb_tdm_link_port;
   import tdm_port_pkg::*;
   logic         clk, nrst, rd, wr, wq;
   logic [7:0]   adr, got;
   logic [31:0]  wd, rdq, rdat;
   logic [1:0]   rsp, rs, pll;
   logic [15:0]  txl, txoe, pin_o, pin_oe, pin, rxv, rxc, rxd, xtx;
   logic [3:0]   refc;
   logic [127:0] rxb;
   int           miscompares, comparisons;
   assign pin = (pin_oe & xtx) | (~pin_oe & pin_o);
   tdm_link_port i_tdm_link_port (.i_clk(clk), .i_nrst(nrst), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
      .o_avs_readdata(rdq), .o_avs_waitrequest(wq), .o_avs_response(rsp),
      .o_serial_tx_line(txl), .o_serial_tx_line_oe_n(txoe), .i_serial_rx_line(rxd),
      .i_link_tx_clock_pin(pin), .o_link_tx_clock_pin(pin_o),
      .o_link_tx_clock_pin_oe_n(pin_oe), .i_link_rx_clock_in(rxc),
      .i_dejittered_ref_clock_in(refc), .o_ext_pll_ref_out(pll),
      .i_tx_bytes({16{8'h1D}}), .o_rx_bytes(rxb), .o_rx_valid(rxv));
   tdm_xcvr_model i_tdm_xcvr_model (.o_rx_clk(rxc), .o_rx_data(rxd), .o_ref_clk(refc),
      .o_tx_clk(xtx));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // No frame sync, so any rotation of the repeated byte is acceptable
   function automatic logic [31:0] is_rot(input logic [7:0] b);
      is_rot = 32'h0;
      for (int r = 0; r < 8; r++) if (8'({b, b} >> r) == 8'h1D) is_rot = 32'h1;
   endfunction
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk);
      while (wq !== 1'b0 && n < 200) begin
         n++;
         @(posedge clk);
      end
      if (n == 200) miscompares++;
      // Answer is taken at the very edge waitrequest is seen low
      rs = rsp;
      if (!w) rdat = rdq;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic t_regs();
      bus(1'b0, TX_CTRL_BASE + 8'h04, 32'h0);
      check(rdat, TXC_RST);
      bus(1'b0, RX_FREQ_BASE + 8'h3C, 32'h0);
      check(rdat, 32'(RXF_RST));
      bus(1'b1, RX_FREQ_BASE + 8'h08, 32'h0000_0123);
      bus(1'b0, RX_FREQ_BASE + 8'h08, 32'h0);
      check(rdat, 32'h0000_0123);
      check(32'(rs), 32'h0);
      bus(1'b0, 8'h90, 32'h0);
      check(32'(rs), 32'h3);
      bus(1'b1, 8'hA0, 32'h1);
      check(32'(rs), 32'h3);
   endtask
   task automatic t_tx();
      logic [31:0] cfg [4] = '{32'h0000_0101, 32'h0000_0033, 32'h0000_0131, 32'h0};
      check(32'(txoe), 32'hFFFF);
      bus(1'b1, SLOT_EN_BASE, 32'hFFFF_FFFF);
      bus(1'b1, LINK_EN_ADDR, 32'h0000_0001);
      foreach (cfg[c]) begin
         bus(1'b1, TX_CTRL_BASE, cfg[c]);
         repeat (100) @(posedge clk);
         check(32'(pin_oe[0]), 32'(!cfg[c][0]));
         for (int i = 0; i < 8; i++) begin
            if (cfg[c][1]) @(posedge pin[0]);
            else @(negedge pin[0]);
            got = {got[6:0], txl[0]};
            check(32'(txoe[0]), 32'h0);
         end
         check(is_rot(got), 32'h1);
         if (cfg[c][0]) begin
            // Just after an rx clock rise every reference is still low
            @(posedge rxc[0]);
            repeat (6) @(negedge clk);
            check(32'(pin[0]), 32'(c == 1));
         end
      end
      bus(1'b1, SLOT_EN_BASE, 32'h0);
      repeat (100) @(posedge clk);
      check(32'(txoe[0]), 32'h1);
   endtask
   task automatic t_rx();
      int n;
      bus(1'b1, LINK_EN_ADDR, 32'h0000_FFFF);
      for (int k = 0; k < NUM_LINKS; k++) begin
         n = 0;
         while (rxv[k] !== 1'b1 && n < 1000) begin
            n++;
            @(negedge clk);
         end
         check(is_rot(rxb[8*k +: 8]), 32'h1);
      end
   endtask
   task automatic t_freq();
      repeat (300) @(posedge clk);
      bus(1'b0, STATUS_ADDR, 32'h0);
      check(32'(rdat[31:16]), 32'hFFFB);
      bus(1'b1, RX_FREQ_BASE + 8'h08, 32'(RXF_RST));
      repeat (300) @(posedge clk);
      bus(1'b0, STATUS_ADDR, 32'h0);
      check(32'(rdat[31:16]), 32'hFFFF);
   endtask
   task automatic t_pll();
      bus(1'b1, PLL_SEL_ADDR, 32'(SRC_REF0));
      repeat (2) begin
         @(negedge refc[0]);
         repeat (6) @(negedge clk);
         check(32'(pll), 32'h0);
         @(posedge refc[0]);
         repeat (6) @(negedge clk);
         check(32'(pll), 32'h3);
      end
   endtask
   task automatic conclude();
      $display("miscompares %0d comparisons %0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      nrst = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      adr = 8'h00;
      wd = 32'h0;
      got = 8'h00;
      miscompares = 0;
      comparisons = 0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      t_regs();
      t_tx();
      t_rx();
      t_freq();
      t_pll();
      conclude();
   end
   initial begin
      #300000;
      miscompares++;
      conclude();
   end
endmodule // tb_tdm_link_port
